/* sc_xfer_pkg.sv */
// shared constants and types of the smart card transfer control block
package sc_xfer_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_CONTACT  = 8'h08;
  localparam logic [7:0] OFS_ETU      = 8'h0c;
  localparam logic [7:0] OFS_WAIT     = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h18;
  localparam logic [7:0] OFS_PENDING  = 8'h1c;
  localparam logic [7:0] OFS_TX_BUF   = 8'h20;
  localparam logic [7:0] OFS_RX_BUF   = 8'h24;
  localparam logic [7:0] OFS_PRESCALE = 8'h28;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL_LSB    = 1;
  localparam int CONTACT_LSB = 2;
  localparam int ST_PARITY  = 0;
  localparam int ST_RX_DONE = 1;
  localparam int ST_TX_DONE = 2;
  localparam int ST_WT_OVER = 3;
  localparam int IE_PARITY  = 0;
  localparam int IE_CARD    = 1;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [10:0] RST_ETU      = 11'h174;
  localparam logic [23:0] RST_WAIT     = 24'h002580;
  localparam logic [5:0]  RST_PRESCALE = 6'h00;
  localparam logic [2:0]  RST_CONTACT  = 3'h2;
  localparam logic [3:0]  LAST_BIT     = 4'h9;
  localparam logic [3:0]  ERR_FIRST    = 4'hb;
  localparam logic [3:0]  ERR_LAST     = 4'hc;
  localparam logic [3:0]  GUARD_ETUS   = 4'h2;
  localparam logic [2:0]  TRIES_SHORT  = 3'h4;
  localparam logic [2:0]  TRIES_LONG   = 3'h5;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic detectType;
    logic xferEn;
    logic retrySel;
    logic modeSel;
    logic waitEn;
    logic repeatEn;
  } ctrl_s;

  typedef struct packed {
    logic card_clock_source_sel;
    logic dataLvl;
    logic clockLvl;
  } contact_s;

  typedef enum logic [2:0] {
    S_IDLE,
    S_TXBIT,
    S_TXCHK,
    S_RXBIT,
    S_RXERR,
    S_GUARD
  } xfer_state_e;

endpackage : sc_xfer_pkg

/* sc_bit_timer.sv */
// card clock prescaler and elementary time unit tick generator
`timescale 1ns/100ps
module sc_bit_timer
  import sc_xfer_pkg::*;
#(
  parameter int PSC_W = 6,
  parameter int ETU_W = 11
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // settings
  input  wire logic [PSC_W-1:0] prescale,
  input  wire logic [ETU_W-1:0] etuLen,
  input  wire logic             restart,
  // outputs
  output logic                  cardClk,
  output logic                  etuTick,
  output logic                  midTick
);

  logic [PSC_W-1:0] pscCnt_q;
  logic [ETU_W-1:0] etuCnt_q;
  logic             clk_q;

  wire pscWrap  = (pscCnt_q == prescale);
  wire cardRise = pscWrap & ~clk_q;
  wire etuWrap  = cardRise & (etuCnt_q >= etuLen - {{(ETU_W-1){1'b0}}, 1'b1});

  assign cardClk = clk_q;
  assign etuTick = etuWrap & ~restart;
  assign midTick = cardRise & (etuCnt_q == (etuLen >> 1)) & ~restart;

  // card clock keeps running across restarts; only the bit phase realigns
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pscCnt_q <= '0;
      clk_q    <= 1'b0;
    end else if (pscWrap) begin
      pscCnt_q <= '0;
      clk_q    <= ~clk_q;
    end else begin
      pscCnt_q <= pscCnt_q + {{(PSC_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      etuCnt_q <= '0;
    end else if (restart || etuWrap) begin
      etuCnt_q <= '0;
    end else if (cardRise) begin
      etuCnt_q <= etuCnt_q + {{(ETU_W-1){1'b0}}, 1'b1};
    end
  end

endmodule : sc_bit_timer

/* smart_card_transfer_control.sv */
// smart card transfer control: waiting timer, pin control, card detect, character engine
//
// How it works
// [R01] waiting counter is 24 bits, counting down once per elementary time unit
// [R02] automatic mode with counter enabled: start bit reloads counter from wait register
// [R03] software enables the waiting counter in automatic mode only after card insertion
// [R04] manual mode: counter is a general timer gated by its enable bit
// [R05] manual mode, counter enabled: wait register writes leave running counter alone
// [R06] manual mode, counter disabled: wait register write loads counter at once
// [R07] software may rewrite waiting time while running, block then character time
// [R08] manual mode mirrors manual data level on data pin; automatic mode drives it
// [R09] clock select chooses manual clock level or prescaled clock for card clock pin
// [R10] insertion and removal both detected, pending bit raised when enabled
// [R11] switch type bit makes card present read one whenever card is there
// [R12] no debounce: every detect pin change shows on present flag
// [R13] automatic mode moves characters over half duplex clock and data pins
// [R14] after reset: reception direction, transfer disabled
// [R15] writing transmit buffer in automatic mode turns direction to transmission
// [R16] transmit done, receive done and buffer empty flags reflect completions
// [R17] parity generated and checked; error sets flag and enabled pending bit
// [R18] clean character sets its done flag and clears parity flag
// [R19] repetition enable plus select between four and five attempts, one meaning four
// [R20] transmit retries on card error; at limit parity flag, no done, buffer drained
// [R21] receive signals errors up to limit; then parity and receive done set
// [R22] without repetition: receive error sets both flags, transmit error parity only
// [R23] pending register read-only, cleared by its read; status flags cleared separately
// [R24] receiver signals parity error by pulling data low during guard time
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module smart_card_transfer_control
  import sc_xfer_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // card pins
  input  wire logic        cardDataIn,
  output logic             cardDataOut,
  output logic             cardDataOe,
  output logic             cardClockPin,
  input  wire logic        cardDetectPin
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  ctrl_s       ctrl_q;
  contact_s    contact_q;
  xfer_state_e state_q, state_d;
  logic [10:0] etu_q;
  logic [23:0] wait_q, wtCnt_q, wtCnt_d;
  logic [5:0]  psc_q;
  logic [1:0]  ie_q, pend_q, pend_d;
  logic        parFlag_q, rxDone_q, txDone_q, wtOver_q;
  logic        detMeta_q, detSync_q, detPrev_q, datMeta_q, datSync_q;
  logic [31:0] prdata_q;
  logic        clkPin_q, pinLow_q, pinLow_d, dirTx_q, bufFull_q, bufFull_d;
  logic [7:0]  txBuf_q, txData_q, txData_d, rxBuf_q, rxBuf_d;
  logic [10:0] txShift_q, txShift_d;
  logic [8:0]  rxShift_q, rxShift_d;
  logic [3:0]  bitCnt_q, bitCnt_d;
  logic [2:0]  tries_q, tries_d;
  logic        resend_q, resend_d, errSeen_q, errSeen_d;
  logic        startPulse, txOk, txGiveUp, rxFinal, rxErr, dirRelease;
  logic        timerClk, etuTick, midTick;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire wrEn    = access & pwrite;
  wire selCtl  = paddr == OFS_CONTROL;
  wire selSt   = paddr == OFS_STATUS;
  wire selCc   = paddr == OFS_CONTACT;
  wire selEtu  = paddr == OFS_ETU;
  wire selWt   = paddr == OFS_WAIT;
  wire selIe   = paddr == OFS_IRQ_EN;
  wire selPend = paddr == OFS_PENDING;
  wire selTxb  = paddr == OFS_TX_BUF;
  wire selRxb  = paddr == OFS_RX_BUF;
  wire selPsc  = paddr == OFS_PRESCALE;
  wire hit     = selCtl | selSt | selCc | selEtu | selWt | selIe | selPend | selTxb | selRxb | selPsc;
  wire wrSt    = wrEn & selSt;
  wire wrWt    = wrEn & selWt;
  wire wrEtu   = wrEn & selEtu;
  wire txbWr   = wrEn & selTxb;
  wire pendRd  = access & ~pwrite & selPend; // [R23]

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire        present = detSync_q ^ ctrl_q.detectType; // [R11] [R12]
  wire [7:0]  stWord  = {~bufFull_q, present, 2'b00, wtOver_q, txDone_q, rxDone_q, parFlag_q}; // [R16]
  wire [31:0] rdCtl   = {25'h0, ctrl_q, 1'b0};
  wire [31:0] rdCc    = {27'h0, contact_q, 2'b00};
  wire [31:0] rdData  = selCtl  ? rdCtl :
                        selSt   ? {24'h0, stWord} :
                        selCc   ? rdCc :
                        selEtu  ? {21'h0, etu_q} :
                        selWt   ? {8'h0, wait_q} :
                        selIe   ? {30'h0, ie_q} :
                        selPend ? {30'h0, pend_q} :
                        selTxb  ? {24'h0, txBuf_q} :
                        selRxb  ? {24'h0, rxBuf_q} :
                        selPsc  ? {26'h0, psc_q} : 32'h0;

  assign prdata      = prdata_q;
  assign pready      = 1'b1;
  assign pslverr     = access & ~hit;
  assign cardDataOut = 1'b0;
  assign cardDataOe  = pinLow_q;
  assign cardClockPin = clkPin_q;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q    <= '0; // [R14]
      contact_q <= RST_CONTACT;
      etu_q     <= RST_ETU;
      wait_q    <= RST_WAIT;
      psc_q     <= RST_PRESCALE;
      ie_q      <= '0;
      txBuf_q   <= '0;
      prdata_q  <= '0;
    end else begin
      if (wrEn && selCtl) ctrl_q <= ctrl_s'(pwdata[CTL_LSB +: 6]);
      if (wrEn && selCc) contact_q <= contact_s'(pwdata[CONTACT_LSB +: 3]);
      if (wrEtu) etu_q <= pwdata[10:0];
      if (wrWt) wait_q <= pwdata[23:0]; // [R07]
      if (wrEn && selPsc) psc_q <= pwdata[5:0];
      if (wrEn && selIe) ie_q <= pwdata[1:0];
      if (txbWr) txBuf_q <= pwdata[7:0];
      if (setup) prdata_q <= rdData;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers and card detect
  // ---------------------------------------------------------------
  wire cardEvent = detSync_q ^ detPrev_q; // [R10] [R12]

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      detMeta_q <= 1'b0;
      detSync_q <= 1'b0;
      detPrev_q <= 1'b0;
      datMeta_q <= 1'b1;
      datSync_q <= 1'b1;
    end else begin
      detMeta_q <= cardDetectPin;
      detSync_q <= detMeta_q;
      detPrev_q <= detSync_q;
      datMeta_q <= cardDataIn;
      datSync_q <= datMeta_q;
    end
  end

  // ---------------------------------------------------------------
  // bit timing
  // ---------------------------------------------------------------
  sc_bit_timer #(
    .PSC_W (6),
    .ETU_W (11)
  ) u_timer (
    .mclk     (mclk),
    .rstn     (rstn),
    .prescale (psc_q),
    .etuLen   (etu_q),
    .restart  (startPulse | wrEtu),
    .cardClk  (timerClk),
    .etuTick  (etuTick),
    .midTick  (midTick)
  );

  // ---------------------------------------------------------------
  // waiting time counter
  // ---------------------------------------------------------------
  wire wtLoadAuto = startPulse & ctrl_q.modeSel & ctrl_q.waitEn; // [R02]
  wire wtLoadMan  = ~ctrl_q.modeSel & ~ctrl_q.waitEn & wrWt; // [R05] [R06]
  wire wtDec      = ctrl_q.waitEn & etuTick & (wtCnt_q != 24'h0); // [R01] [R04]
  wire wtOverSet  = wtDec & (wtCnt_q == 24'h1) & ~wtLoadAuto;

  assign wtCnt_d = wtLoadAuto ? wait_q :
                   wtLoadMan  ? pwdata[23:0] :
                   wtDec      ? wtCnt_q - 24'h1 : wtCnt_q;

  // ---------------------------------------------------------------
  // character engine
  // ---------------------------------------------------------------
  wire       active   = ctrl_q.modeSel & ctrl_q.xferEn; // [R13] [R14]
  wire [2:0] limit    = ctrl_q.retrySel ? TRIES_SHORT : TRIES_LONG; // [R19]
  wire [2:0] triesNxt = tries_q + 3'h1;
  wire       mayRetry = ctrl_q.repeatEn & (triesNxt < limit); // [R19]
  wire [7:0] txPick   = resend_q ? txData_q : txBuf_q;
  wire [8:0] rxIn     = {datSync_q, rxShift_q[8:1]};
  wire       rxBad    = ^rxIn; // [R17]

  always_comb begin
    state_d    = state_q;
    bitCnt_d   = bitCnt_q;
    txShift_d  = txShift_q;
    rxShift_d  = rxShift_q;
    tries_d    = tries_q;
    resend_d   = resend_q;
    errSeen_d  = errSeen_q;
    txData_d   = txData_q;
    rxBuf_d    = rxBuf_q;
    bufFull_d  = bufFull_q | txbWr;
    startPulse = 1'b0;
    txOk       = 1'b0;
    txGiveUp   = 1'b0;
    rxFinal    = 1'b0;
    rxErr      = 1'b0;
    dirRelease = 1'b0;
    if (!active) begin
      state_d  = S_IDLE; // [R14]
      tries_d  = '0;
      resend_d = 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (dirTx_q && (bufFull_q || resend_q)) begin
            startPulse = 1'b1;
            bufFull_d  = txbWr | (bufFull_q & resend_q); // [R20]
            txData_d   = txPick;
            txShift_d  = {1'b1, ^txPick, txPick, 1'b0}; // [R17]
            bitCnt_d   = '0;
            state_d    = S_TXBIT;
          end else if (!dirTx_q && !datSync_q) begin
            startPulse = 1'b1;
            bitCnt_d   = '0;
            state_d    = S_RXBIT;
          end
        end
        S_TXBIT: begin
          if (etuTick) begin
            txShift_d = {1'b1, txShift_q[10:1]};
            bitCnt_d  = bitCnt_q + 4'h1;
            errSeen_d = 1'b0;
            if (bitCnt_q == LAST_BIT) state_d = S_TXCHK;
          end
        end
        S_TXCHK: begin
          if (midTick) errSeen_d = ~datSync_q;
          if (etuTick) begin
            bitCnt_d = '0;
            state_d  = S_GUARD;
            if (!errSeen_q) begin
              txOk     = 1'b1; // [R18]
              tries_d  = '0;
              resend_d = 1'b0;
            end else if (mayRetry) begin
              tries_d  = triesNxt; // [R20]
              resend_d = 1'b1;
            end else begin
              txGiveUp = 1'b1; // [R20] [R22]
              tries_d  = '0;
              resend_d = 1'b0;
            end
          end
        end
        S_RXBIT: begin
          if (midTick) begin
            bitCnt_d = bitCnt_q + 4'h1;
            if (bitCnt_q == 4'h0) begin
              if (datSync_q) state_d = S_IDLE;
            end else begin
              rxShift_d = rxIn;
              if (bitCnt_q == LAST_BIT) begin
                if (rxBad && mayRetry) begin
                  tries_d = triesNxt; // [R21]
                  state_d = S_RXERR;
                end else begin
                  rxFinal  = 1'b1; // [R21] [R22]
                  rxErr    = rxBad;
                  rxBuf_d  = rxIn[7:0];
                  tries_d  = '0;
                  bitCnt_d = '0;
                  state_d  = S_GUARD;
                end
              end
            end
          end
        end
        S_RXERR: begin
          if (midTick) begin
            bitCnt_d = bitCnt_q + 4'h1;
            if (bitCnt_q == ERR_LAST) state_d = S_IDLE; // [R24]
          end
        end
        S_GUARD: begin
          if (etuTick) begin
            bitCnt_d = bitCnt_q + 4'h1;
            if (bitCnt_q == GUARD_ETUS - 4'h1) begin
              state_d    = S_IDLE;
              dirRelease = ~bufFull_q & ~resend_q;
            end
          end
        end
        default: state_d = S_IDLE;
      endcase
    end
  end

  // open drain: low while manual level is 0, a zero bit, or the error signal
  wire engineLow = ((state_q == S_TXBIT) & ~txShift_q[0]) | ((state_q == S_RXERR) & (bitCnt_q >= ERR_FIRST));
  assign pinLow_d = ctrl_q.modeSel ? (ctrl_q.xferEn & engineLow) : ~contact_q.dataLvl; // [R08] [R24]

  // ---------------------------------------------------------------
  // flags; hardware set wins over software clear
  // ---------------------------------------------------------------
  wire parSet = txGiveUp | (rxFinal & rxErr); // [R17] [R20] [R21] [R22]
  wire parClr = txOk | (rxFinal & ~rxErr); // [R18]
  assign pend_d[IE_PARITY] = (parSet & ie_q[IE_PARITY]) | (pend_q[IE_PARITY] & ~pendRd); // [R17] [R23]
  assign pend_d[IE_CARD]   = (cardEvent & ie_q[IE_CARD]) | (pend_q[IE_CARD] & ~pendRd); // [R10] [R23]

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      parFlag_q <= 1'b0;
      rxDone_q  <= 1'b0;
      txDone_q  <= 1'b0;
      wtOver_q  <= 1'b0;
      pend_q    <= '0;
    end else begin
      parFlag_q <= parSet | (parFlag_q & ~parClr & ~(wrSt & pwdata[ST_PARITY]));
      rxDone_q  <= rxFinal | (rxDone_q & ~(wrSt & pwdata[ST_RX_DONE])); // [R16]
      txDone_q  <= txOk | (txDone_q & ~(wrSt & pwdata[ST_TX_DONE])); // [R16]
      wtOver_q  <= wtOverSet | (wtOver_q & ~(wrSt & pwdata[ST_WT_OVER]));
      pend_q    <= pend_d;
    end
  end

  // ---------------------------------------------------------------
  // engine and pin state
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= S_IDLE;
      bitCnt_q  <= '0;
      txShift_q <= '1;
      rxShift_q <= '0;
      tries_q   <= '0;
      resend_q  <= 1'b0;
      errSeen_q <= 1'b0;
      txData_q  <= '0;
      rxBuf_q   <= '0;
      bufFull_q <= 1'b0;
      dirTx_q   <= 1'b0; // [R14]
      wtCnt_q   <= RST_WAIT;
      pinLow_q  <= 1'b0;
      clkPin_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      bitCnt_q  <= bitCnt_d;
      txShift_q <= txShift_d;
      rxShift_q <= rxShift_d;
      tries_q   <= tries_d;
      resend_q  <= resend_d;
      errSeen_q <= errSeen_d;
      txData_q  <= txData_d;
      rxBuf_q   <= rxBuf_d;
      bufFull_q <= bufFull_d;
      dirTx_q   <= (ctrl_q.modeSel & txbWr) | (dirTx_q & ~dirRelease); // [R15]
      wtCnt_q   <= wtCnt_d;
      pinLow_q  <= pinLow_d;
      clkPin_q  <= contact_q.card_clock_source_sel ? timerClk : contact_q.clockLvl; // [R09]
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_wt_start_load: assert property (wtLoadAuto |=> wtCnt_q == $past(wait_q)) // [R02]
    else $error("wait counter not loaded at start bit");
  a_wt_man_hold: assert property ((!ctrl_q.modeSel && ctrl_q.waitEn && wrWt && !etuTick)
    |=> wtCnt_q == $past(wtCnt_q)) // [R05]
    else $error("running wait counter took a new value");
  a_wt_man_load: assert property ((!ctrl_q.modeSel && !ctrl_q.waitEn && wrWt)
    |=> wtCnt_q == $past(pwdata[23:0]) ##1 wtCnt_q == $past(wtCnt_q, 1)) // [R06]
    else $error("stopped wait counter not loaded by write");
  a_wt_expire: assert property (wtOverSet |=> wtCnt_q == 24'h0 && wtOver_q) // [R01]
    else $error("wait counter underflow not flagged");
  a_data_manual: assert property (!ctrl_q.modeSel |=> cardDataOe == !$past(contact_q.dataLvl)) // [R08]
    else $error("data pin not mirroring manual level");
  a_clk_manual: assert property (!contact_q.card_clock_source_sel |=> cardClockPin == $past(contact_q.clockLvl)) // [R09]
    else $error("clock pin not mirroring manual level");
  a_card_pend: assert property ((cardEvent && ie_q[IE_CARD]) |=> pend_q[IE_CARD]) // [R10]
    else $error("card change not pending");
  a_tx_turn: assert property ((ctrl_q.modeSel && txbWr) |=> dirTx_q && bufFull_q) // [R15]
    else $error("buffer write did not turn direction");
  a_clean_done: assert property ($rose(txDone_q) || $rose(rxDone_q) && !$past(rxErr) |-> !parFlag_q) // [R18]
    else $error("clean character left parity flag");
  a_rx_fail: assert property ((rxFinal && rxErr) |=> parFlag_q && rxDone_q) // [R21]
    else $error("receive error flags not both set");
  a_tx_fail: assert property (txGiveUp |=> parFlag_q && !$rose(txDone_q)) // [R20]
    else $error("transmit failure flags wrong");
  a_err_signal: assert property ((state_q == S_RXERR && bitCnt_q == ERR_LAST) |-> cardDataOe) // [R24]
    else $error("error signal not driven");
  a_off_idle: assert property (!ctrl_q.xferEn |=> state_q == S_IDLE) // [R14]
    else $error("engine busy while disabled");
  a_pend_clear: assert property ((pendRd && !parSet && !cardEvent) |=> pend_q == 2'b00) // [R23]
    else $error("pending read did not clear");

  c_tx_done: cover property ($rose(txDone_q));
  c_rx_done: cover property ($rose(rxDone_q));
  c_rx_retry: cover property (state_q == S_RXERR);
  c_tx_giveup: cover property (txGiveUp);
  c_card_event: cover property (cardEvent);

endmodule : smart_card_transfer_control

/* sc_card_model.sv */
// behavioural smart card on the open-drain data line
`timescale 1ns/100ps
module sc_card_model #(
  parameter int ETU = 32
) (
  // clock
  input  wire logic mclk,
  // data line
  input  wire logic dataLine,
  output logic      cardLow
);
  initial cardLow = 1'b0;
  // start, eight bits lsb first, parity; line released after
  task automatic send(input logic [7:0] d, input logic p);
    logic [9:0] f;
    f = {p, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      cardLow <= ~f[i];
      repeat (ETU - 1) @(posedge mclk);
    end
    @(posedge mclk);
    cardLow <= 1'b0;
  endtask : send
  // samples at mid bit; never signals errors
  task automatic recv(output logic [7:0] d, output logic p, output logic ok);
    logic [8:0] f;
    int         n;
    n = 0;
    while (dataLine !== 1'b0 && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    ok = (n < 4000);
    repeat (ETU / 2) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      repeat (ETU) @(posedge mclk);
      f[i] = dataLine;
    end
    d = f[7:0];
    p = f[8];
  endtask : recv
endmodule : sc_card_model

/* tb.sv */
// self-checking testbench of the smart card transfer control
`timescale 1ns/100ps
module tb;
  import sc_xfer_pkg::*;
  logic        mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, b, got;
  logic [31:0] pwdata = 32'h0, prdata, rd, err;
  logic        pready, pslverr, cardDataOut, cardDataOe, cardClockPin, cardLow, par, ok;
  logic        cardDetectPin = 1'b0;
  int          num_errors = 0, comparisons = 0, w;
  // pull-up on the data line
  wire         dataLine = (cardDataOe | cardLow) ? 1'b0 : 1'b1;
  always #20 mclk = ~mclk;
  smart_card_transfer_control u_smart_card_transfer_control (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cardDataIn(dataLine), .cardDataOut(cardDataOut), .cardDataOe(cardDataOe),
    .cardClockPin(cardClockPin), .cardDetectPin(cardDetectPin));
  sc_card_model #(.ETU(32)) u_sc_card_model (.mclk(mclk), .dataLine(dataLine), .cardLow(cardLow));
  task automatic test_done();
    if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      test_done();
    end
    rd      = prdata;
    err     = {31'h0, pslverr};
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdchk
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    w = $urandom(32'h6d176ce2);
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    rdchk(OFS_STATUS, 32'h80, 32'hffffffff);
    rdchk(OFS_CONTROL, 32'h0, 32'hffffffff);
    apb(1'b0, 8'h3c, 32'h0);
    chk(err, 32'h1);
    apb(1'b1, OFS_CONTACT, 32'h0);
    repeat (3) @(posedge mclk);
    chk({31'h0, cardDataOe}, 32'h1);
    b = 8'($urandom);
    apb(1'b1, OFS_CONTACT, {29'h1, b[0], 2'h0});
    repeat (3) @(posedge mclk);
    chk({30'h0, cardDataOe, cardClockPin}, {31'h0, b[0]});
    // short etu keeps the waiting timer and frames quick
    apb(1'b1, OFS_ETU, 32'h10);
    w = 2 + $urandom % 4;
    apb(1'b1, OFS_WAIT, w);
    apb(1'b1, OFS_CONTROL, 32'h04);
    apb(1'b1, OFS_WAIT, 32'hffffff);
    repeat ((w - 1) * 32 - 16) @(posedge mclk);
    rdchk(OFS_STATUS, 32'h0, 32'h08);
    repeat (60) @(posedge mclk);
    rdchk(OFS_STATUS, 32'h08, 32'h08);
    apb(1'b1, OFS_CONTROL, 32'h0);
    apb(1'b1, OFS_IRQ_EN, 32'h3);
    apb(1'b0, OFS_PENDING, 32'h0);
    cardDetectPin <= 1'b1;
    repeat (4) @(posedge mclk);
    rdchk(OFS_STATUS, 32'h40, 32'h40);
    rdchk(OFS_PENDING, 32'h2, 32'h2);
    rdchk(OFS_PENDING, 32'h0, 32'h2);
    cardDetectPin <= 1'b0;
    repeat (4) @(posedge mclk);
    rdchk(OFS_STATUS, 32'h0, 32'h40);
    apb(1'b1, OFS_CONTROL, 32'h40);
    rdchk(OFS_STATUS, 32'h40, 32'h40);
    apb(1'b1, OFS_CONTACT, 32'h18);
    apb(1'b1, OFS_CONTROL, 32'h68);
    for (int i = 0; i < 2; i++) begin
      b = i ? 8'h00 : 8'($urandom);
      apb(1'b1, OFS_TX_BUF, {24'h0, b});
      u_sc_card_model.recv(got, par, ok);
      chk({23'h0, ok, got}, {24'h1, b});
      chk({31'h0, par}, {31'h0, ^b});
      repeat (120) @(posedge mclk);
      rdchk(OFS_STATUS, 32'h84, 32'h87);
      apb(1'b1, OFS_STATUS, 32'h0f);
    end
    b = 8'($urandom);
    u_sc_card_model.send(b, ^b);
    repeat (64) @(posedge mclk);
    rdchk(OFS_STATUS, 32'h02, 32'h07);
    rdchk(OFS_RX_BUF, {24'h0, b}, 32'hff);
    apb(1'b1, OFS_STATUS, 32'h0f);
    apb(1'b0, OFS_PENDING, 32'h0);
    repeat (100) @(posedge mclk);
    u_sc_card_model.send(b, ~^b);
    repeat (64) @(posedge mclk);
    rdchk(OFS_STATUS, 32'h03, 32'h07);
    rdchk(OFS_PENDING, 32'h1, 32'h1);
    // repetition on, four tries: three error signals, flags only on the last
    apb(1'b1, OFS_STATUS, 32'h0f);
    apb(1'b1, OFS_CONTROL, 32'h7a);
    repeat (100) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      u_sc_card_model.send(b, ~^b);
      repeat (64) @(posedge mclk);
      if (i < 3) chk({31'h0, cardDataOe}, 32'h1);
      if (i < 3) rdchk(OFS_STATUS, 32'h00, 32'h07);
      repeat (100) @(posedge mclk);
    end
    rdchk(OFS_STATUS, 32'h03, 32'h07);
    test_done();
  end
endmodule : tb
